// ### verilog/irf_consts.svh
`ifndef IRF_CONSTS_SVH
`define IRF_CONSTS_SVH

// Data path width of results and compare operands.
`define IRF_DATA_W 16
// Width of the fault code and error step words.
`define IRF_WORD_W 16
// Reset value of every flag.
`define IRF_FLAG_RST 1'h0
// Reset value of the fault code and error step words.
`define IRF_WORD_RST 16'h0000

`endif

// ### verilog/irf_pkg.sv
package irf_pkg;

	// Result condition flags of the most recent operation.
	typedef struct packed {
		logic op_error;
		logic zero;
		logic carry;
		logic overflow;
	} irf_result_flags_t;

	// Relation flags set by a compare instruction.
	typedef struct packed {
		logic rel_less;
		logic rel_less_or_equal;
		logic rel_equal;
		logic rel_greater;
		logic rel_greater_or_equal;
		logic rel_not_equal;
	} irf_rel_flags_t;

	// Whole state of the flag unit.
	typedef struct packed {
		logic [1:0]        rst_sync;
		irf_result_flags_t res;
		logic              op_error_latch;
		logic              all_outputs_off;
		irf_rel_flags_t    rel;
		logic [15:0]       fault_code;
		logic [15:0]       error_step;
	} irf_state_t;

endpackage

// ### verilog/irf_flags.sv
// How it works
// RL1 - Operation error flag set when the executed instruction reports an error.
// RL2 - Zero flag high when the result is zero, low otherwise.
// RL3 - Carry flag set when the operation carries out of the width.
// RL4 - Latched error flag sets on any error and stays set until latch_clear.
// RL5 - Overflow flag set when the result exceeds its range.
// RL6 - Compare sets six relation flags from the two operands.
// RL7 - Fault report instruction stores its 16-bit code.
// RL8 - Program step of an error is stored in a 16-bit word.
// RL9 - Output-disabling instruction sets the all-outputs-off flag.
// RL10 - Non-sticky flags follow only the latest operation.
`timescale 1ns/1ps
`include "irf_consts.svh"

module irf_flags #(
	parameter int DATA_W = `IRF_DATA_W
) (
	input  wire logic                      clock,
	input  wire logic                      rst_b,
	input  wire logic                      op_done,
	input  wire logic [DATA_W-1:0]         op_result,
	input  wire logic                      op_error_in,
	input  wire logic                      op_carry_in,
	input  wire logic                      op_overflow_in,
	input  wire logic                      compare_instruction,
	input  wire logic                      compare_signed,
	input  wire logic [DATA_W-1:0]         cmp_src1,
	input  wire logic [DATA_W-1:0]         cmp_src2,
	input  wire logic                      user_fault_report_instruction,
	input  wire logic [15:0]               fault_code_in,
	input  wire logic [15:0]               step_number,
	input  wire logic                      outputs_off_instruction,
	input  wire logic                      outputs_on_instruction,
	input  wire logic                      latch_clear,
	output logic                           flag_op_error,
	output logic                           flag_zero,
	output logic                           flag_carry,
	output logic                           flag_overflow,
	output logic                           flag_op_error_latch,
	output logic                           flag_all_outputs_off,
	output irf_pkg::irf_rel_flags_t        rel_flags,
	output logic [15:0]                    fault_code,
	output logic [15:0]                    error_step
);

	// The whole state of the unit lives in one packed struct.
	// The reset synchroniser stages are part of that struct as well.
	irf_pkg::irf_state_t        state_q;
	irf_pkg::irf_state_t        state_d;

	// Helper values computed from the inputs of the current cycle.
	irf_pkg::irf_result_flags_t res_next;
	irf_pkg::irf_rel_flags_t    rel_next;
	logic                       rst_int_b;
	logic                       lt;
	logic                       eq;
	logic                       result_is_zero;
	logic                       error_event;
	logic                       latch_next;
	logic                       off_next;

	// The internal reset is the second synchroniser stage.
	// It stays low for two edges after the raw reset is released.
	assign rst_int_b = state_q.rst_sync[1];

	// Zero test of the result word, kept apart so the flag logic stays readable.
	assign result_is_zero = (op_result == '0); // RL2

	// An error counts only when the engine marks the operation as executed.
	// Error lines that wiggle between operations are ignored.
	assign error_event = op_done & op_error_in; // RL1

	// Less-than and equal decide all six relations.
	// The engine chooses a signed or an unsigned view of the operands.
	always_comb
	begin
		eq = (cmp_src1 == cmp_src2);
		if (compare_signed)
		begin
			lt = ($signed(cmp_src1) < $signed(cmp_src2));
		end
		else
		begin
			lt = (cmp_src1 < cmp_src2);
		end
	end

	// All six relation bits come from less-than and equal alone.
	// Deriving them this way means two of them can never contradict each other.
	always_comb
	begin
		rel_next.rel_less             = lt; // RL6
		rel_next.rel_less_or_equal    = lt | eq; // RL6
		rel_next.rel_equal            = eq; // RL6
		rel_next.rel_greater          = ~(lt | eq); // RL6
		rel_next.rel_greater_or_equal = ~lt; // RL6
		rel_next.rel_not_equal        = ~eq; // RL6
	end

	// Result flags of the operation in hand.
	// Each one is cleared when its condition is absent, so none lingers.
	always_comb
	begin
		res_next.op_error = op_error_in; // RL1 RL10
		res_next.zero     = result_is_zero; // RL2 RL10
		res_next.carry    = op_carry_in; // RL3 RL10
		res_next.overflow = op_overflow_in; // RL5 RL10
	end

	// Latched error flag.
	// The set wins over the clear, so an error in the clear cycle is never lost.
	always_comb
	begin
		latch_next = state_q.op_error_latch;
		if (latch_clear)
		begin
			latch_next = `IRF_FLAG_RST;
		end
		if (error_event)
		begin
			latch_next = 1'h1; // RL4
		end
	end

	// All-outputs-off flag.
	// The off instruction wins over an on instruction in the same cycle, the safe choice.
	always_comb
	begin
		off_next = state_q.all_outputs_off;
		if (outputs_on_instruction)
		begin
			off_next = `IRF_FLAG_RST;
		end
		if (outputs_off_instruction)
		begin
			off_next = 1'h1; // RL9
		end
	end

	// Next state of every flag and word.
	// Words and relation bits hold until their own strobe comes again.
	always_comb
	begin
		state_d                 = state_q;
		state_d.rst_sync        = {state_q.rst_sync[0], 1'h1};
		state_d.op_error_latch  = latch_next; // RL4
		state_d.all_outputs_off = off_next; // RL9
		if (op_done)
		begin
			state_d.res = res_next; // RL10
		end
		if (error_event)
		begin
			state_d.error_step = step_number; // RL8
		end
		if (compare_instruction)
		begin
			state_d.rel = rel_next; // RL6
		end
		if (user_fault_report_instruction)
		begin
			state_d.fault_code = fault_code_in; // RL7
		end
	end

	// One register process for the whole state.
	// The raw reset clears everything at once; the synchronised copy then holds
	// the flags at their reset values until two edges after release, so a
	// release close to an edge can never leave half of the flags updated.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q.rst_sync        <= 2'h0;
			state_q.res             <= '0;
			state_q.op_error_latch  <= `IRF_FLAG_RST;
			state_q.all_outputs_off <= `IRF_FLAG_RST;
			state_q.rel             <= '0;
			state_q.fault_code      <= `IRF_WORD_RST;
			state_q.error_step      <= `IRF_WORD_RST;
		end
		else if (!rst_int_b)
		begin
			state_q.rst_sync        <= state_d.rst_sync;
			state_q.res             <= '0;
			state_q.op_error_latch  <= `IRF_FLAG_RST;
			state_q.all_outputs_off <= `IRF_FLAG_RST;
			state_q.rel             <= '0;
			state_q.fault_code      <= `IRF_WORD_RST;
			state_q.error_step      <= `IRF_WORD_RST;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// Result condition flags come straight from the state flip-flops.
	assign flag_op_error        = state_q.res.op_error;
	assign flag_zero            = state_q.res.zero;
	assign flag_carry           = state_q.res.carry;
	assign flag_overflow        = state_q.res.overflow;

	// Latched error and the all-outputs-off indication.
	assign flag_op_error_latch  = state_q.op_error_latch;
	assign flag_all_outputs_off = state_q.all_outputs_off;

	// Relation bits of the last compare.
	assign rel_flags            = state_q.rel;

	// Stored words; they keep their value until the next capturing strobe.
	assign fault_code           = state_q.fault_code;
	assign error_step           = state_q.error_step;

endmodule

// ### sim/irf_flags_chk.sv
`timescale 1ns/1ps
module irf_flags_chk (
	input wire logic                    clock,
	input wire logic                    rst_b,
	input wire logic                    op_done,
	input wire logic [15:0]             op_result,
	input wire logic                    op_error_in,
	input wire logic                    latch_clear,
	input wire logic                    compare_instruction,
	input wire logic [15:0]             cmp_src1,
	input wire logic [15:0]             cmp_src2,
	input wire logic                    flag_op_error,
	input wire logic                    flag_zero,
	input wire logic                    flag_op_error_latch,
	input wire irf_pkg::irf_rel_flags_t rel_flags
);
	// The zero, error, latched error and equal flags are judged one edge after the cycle that triggers the check.
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_zero_result: assert property (op_done |=> flag_zero == ($past(op_result) == 16'h0000))
		else $error("zero flag wrong");
	a_error_follows: assert property (op_done |=> flag_op_error == $past(op_error_in))
		else $error("error flag wrong");
	a_latch_sets: assert property (op_done && op_error_in |=> flag_op_error_latch)
		else $error("latch not set");
	a_latch_holds: assert property (flag_op_error_latch && !latch_clear |=> flag_op_error_latch)
		else $error("latch lost");
	a_latch_clears: assert property (latch_clear && !(op_done && op_error_in) |=> !flag_op_error_latch)
		else $error("latch not cleared");
	a_zero_stands: assert property (!op_done |=> $stable(flag_zero))
		else $error("zero flag moved");
	a_rel_equal: assert property (compare_instruction |=> rel_flags.rel_equal == ($past(cmp_src1) == $past(cmp_src2)))
		else $error("equal flag wrong");
	a_rel_exclusive: assert property (compare_instruction |=> rel_flags.rel_equal ^ rel_flags.rel_not_equal)
		else $error("equal and not equal clash");
endmodule
bind irf_flags irf_flags_chk u_chk (.*);

// ### sim/irf_engine_model.sv
`timescale 1ns/1ps
module irf_engine_model (
	input  wire logic                   clock,
	output logic                        op_done,
	output logic [15:0]                 op_result,
	output irf_pkg::irf_result_flags_t  op_cond
);
	initial {op_done, op_result, op_cond} = '0;
	// Issues one operation, then scrambles the released lines.
	task automatic run(input logic [15:0] r, input logic [3:0] c);
		@(posedge clock);
		op_done <= 1'h1;
		op_result <= r;
		op_cond <= c;
		@(posedge clock);
		op_done <= 1'h0;
		op_result <= ~r;
		op_cond <= ~c;
	endtask
endmodule

// ### sim/instruction_result_flags_tb.sv
`timescale 1ns/1ps
module instruction_result_flags_tb;
	logic clock = 1'h0;
	logic rst_b = 1'h0;
	logic go = 1'h0;
	logic clr = 1'h0;
	logic sgn = 1'h0;
	logic on = 1'h0;
	logic [15:0] s1 = 16'h0000;
	logic [15:0] s2 = 16'h0000;
	logic op_done, latch, off;
	logic [3:0] fl;
	logic [15:0] res, fcode, estep;
	irf_pkg::irf_result_flags_t cond;
	irf_pkg::irf_rel_flags_t rel;
	int err_count = 0;
	int compares = 0;
	always #5 clock = ~clock;
	irf_engine_model eng (.clock(clock), .op_done(op_done), .op_result(res), .op_cond(cond));
	irf_flags dut (.clock(clock), .rst_b(rst_b), .op_done(op_done), .op_result(res),
		.op_error_in(cond.op_error), .op_carry_in(cond.carry), .op_overflow_in(cond.overflow),
		.compare_instruction(go), .compare_signed(sgn), .cmp_src1(s1), .cmp_src2(s2),
		.user_fault_report_instruction(go), .fault_code_in(s1), .step_number(res),
		.outputs_off_instruction(clr), .outputs_on_instruction(on), .latch_clear(clr),
		.flag_op_error(fl[3]), .flag_zero(fl[2]), .flag_carry(fl[1]), .flag_overflow(fl[0]),
		.flag_op_error_latch(latch), .flag_all_outputs_off(off), .rel_flags(rel),
		.fault_code(fcode), .error_step(estep));
	// Counts a comparison and reports a mismatch.
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		compares++;
		if (s !== e)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	// One operation, then its four result flags.
	task automatic op(input logic [15:0] r, input logic [3:0] c);
		eng.run(r, c);
		#1;
		chk("flags", {12'h000, c[3], r == 16'h0000, c[1:0]}, {12'h000, fl});
	endtask
	// One compare, then relations and the stored fault code.
	task automatic cmp(input logic [15:0] a, input logic [15:0] b, input logic sg);
		logic l;
		logic e;
		l = sg ? ($signed(a) < $signed(b)) : (a < b);
		e = (a == b);
		@(posedge clock);
		go <= 1'h1;
		sgn <= sg;
		s1 <= a;
		s2 <= b;
		@(posedge clock);
		go <= 1'h0;
		sgn <= ~sg;
		s1 <= ~a;
		s2 <= ~b;
		#1;
		chk("rel", {10'h000, l, l | e, e, !(l | e), !l, !e}, {10'h000, rel});
		chk("fault", a, fcode);
	endtask
	task automatic t_ops();
		op(16'h0000, 4'h8);
		chk("step", 16'h0000, estep);
		op(16'hFFFF, 4'h3);
		chk("latch", 16'h0001, {15'h0000, latch});
		op(16'h1234, 4'h8);
		chk("step", 16'h1234, estep);
		$display("ops done");
	endtask
	task automatic t_cmp();
		cmp(16'h0003, 16'h0005, 1'h0);
		cmp(16'h0005, 16'h0005, 1'h0);
		cmp(16'h8000, 16'h0002, 1'h0);
		cmp(16'h8000, 16'h0002, 1'h1);
		$display("compare done");
	endtask
	task automatic t_off();
		op(16'h0001, 4'h8);
		@(posedge clock);
		clr <= 1'h1;
		@(posedge clock);
		clr <= 1'h0;
		#1;
		chk("off", 16'h0001, {15'h0000, off});
		chk("latch clear", 16'h0000, {15'h0000, latch});
		@(posedge clock);
		on <= 1'h1;
		@(posedge clock);
		on <= 1'h0;
		#1;
		chk("on", 16'h0000, {15'h0000, off});
		$display("outputs off done");
	endtask
	// Mid-run reset: the stored words must return to zero.
	task automatic t_rst();
		@(posedge clock);
		rst_b <= 1'h0;
		repeat (2) @(posedge clock);
		rst_b <= 1'h1;
		#1;
		chk("rst code", 16'h0000, fcode);
		chk("rst step", 16'h0000, estep);
		repeat (3) @(posedge clock);
		$display("reset done");
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Reset for three cycles, let the synchroniser settle, then run.
	initial
	begin
		repeat (3) @(posedge clock);
		rst_b <= 1'h1;
		repeat (3) @(posedge clock);
		t_ops();
		t_cmp();
		t_off();
		t_rst();
		final_report();
	end
endmodule
